// >>> logic/usdr_pkg.sv
// Constants shared by the serial status and data register block
package usdr_pkg;
  // Byte addresses on the internal bus
  localparam logic [7:0] ADDR_CTRL3 = 8'h3a;
  localparam logic [7:0] ADDR_STAT1 = 8'h3b;
  localparam logic [7:0] ADDR_STAT2 = 8'h3c;
  localparam logic [7:0] ADDR_DATA  = 8'h3d;
  // control_reg_three fields
  localparam int C3_RX8  = 7;
  localparam int C3_TX8  = 6;
  localparam int C3_OVERRUN_IRQ_EN = 3;
  localparam int C3_NOISE_IRQ_EN = 2;
  localparam int C3_FRAMING_IRQ_EN = 1;
  localparam int C3_PARITY_IRQ_EN = 0;
  // status_reg_one fields
  localparam int S1_TXE  = 7;
  localparam int S1_TC   = 6;
  localparam int S1_RXF  = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OR   = 3;
  localparam int S1_NF   = 2;
  localparam int S1_FE   = 1;
  localparam int S1_PE   = 0;
  // status_reg_two fields
  localparam int S2_BKF = 1;
  localparam int S2_RPF = 0;
  // Reset values
  localparam logic [7:0] STAT1_RST = 8'hc0;
  localparam logic [3:0] ERR_EN_RST = 4'h0;
  // Idle run lengths in bit times
  localparam logic [3:0] IDLE_LEN8 = 4'ha;
  localparam logic [3:0] IDLE_LEN9 = 4'hb;
  // Transmit buffer shape
  localparam int TXB_DEPTH = 2;
  localparam int TXB_WIDTH = 8;
endpackage

// >>> logic/usdr_regs.sv
// Status, error flag, ninth bit and data buffer logic of the serial interface
// Function
// - Nine-bit mode: ninth received bit captured with the other eight bits.
// - Eight-bit mode: rx_ninth_bit copies bit seven; reset leaves it alone.
// - tx_ninth_bit goes to the shifter with the buffered byte; reset keeps it.
// - Four error enables gate error requests; reset clears overrun, noise, framing, parity enables.
// - tx_empty_flag sets on hand-off to shifter, interrupts if enabled, reset sets it.
// - tx_empty_flag clears by status read with flag set, then data write.
// - tx_complete_flag set when empty and idle, clears when queued, reset sets.
// - Transmission start lags queueing by at most one and a half bit clocks.
// - rx_full_flag sets on receive transfer, interrupts, clears by status-then-data read.
// - Idle flag sets after ten or eleven ones; interrupts; clears by read sequence.
// - Idle flag held off until a valid character sets rx_full_flag.
// - Overrun sets on character while full; new data dropped, old kept.
// - Data read clears overrun only if it was set at status read.
// - noise_flag sets on noise, interrupts if enabled, clears by read sequence.
// - framing_err_flag sets on zero stop bit, interrupts, clears by read sequence.
// - parity_err_flag sets on parity mismatch, interrupts, clears by read sequence.
// - Break sets break, framing and full flags; clears ninth bit in nine-bit mode.
// - Break flag clears by status two then data read; rearms after ones.
// - rx_in_progress sets on zero in first sample slot; never interrupts.
// - rx_in_progress clears on false start or idle character.
// - Character length selects eight or nine bits and the idle run length.
// - Module disable forces empty and complete flags high, masks transmit interrupts.
`timescale 1ns/10ps
`default_nettype none

module usdr_regs
  import usdr_pkg::*;
#(
  parameter int DEPTH = TXB_DEPTH,
  parameter int WIDTH = TXB_WIDTH
) (
  input  wire logic             clock,           // Module clock
  input  wire logic             arst_n,          // Async reset, active low
  input  wire logic [7:0]       bus_addr,        // Register byte address
  input  wire logic             bus_rd,          // Read strobe
  input  wire logic             bus_wr,          // Write strobe
  input  wire logic [7:0]       bus_wdata,       // Write data
  output logic      [7:0]       bus_rdata,       // Read data, one cycle after strobe
  input  wire logic             module_enable,   // Module enable
  input  wire logic             rx_enable,       // Receiver enable
  input  wire logic             nine_bit_mode,   // Character length select
  input  wire logic             tx_empty_irq_en, // Transmit empty interrupt enable
  input  wire logic             tx_done_irq_en,  // Transmit done interrupt enable
  input  wire logic             rx_full_irq_en,  // Receive full interrupt enable
  input  wire logic             idle_irq_en,     // Idle interrupt enable
  input  wire logic             rx_char_done,    // Received character complete
  input  wire logic [8:0]       rx_char,         // Received character bits
  input  wire logic             rx_noise,        // Noise seen in character
  input  wire logic             rx_stop_zero,    // Stop bit sampled as zero
  input  wire logic             rx_parity_bad,   // Parity mismatch
  input  wire logic             rx_break,        // Break character detected
  input  wire logic             rx_bit_tick,     // One received bit time elapsed
  input  wire logic             rx_bit,          // Sampled receive bit value
  input  wire logic             rx_start_zero,   // Zero in first_rx_sample_slot
  input  wire logic             rx_false_start,  // False start bit rejected
  input  wire logic             tx_busy,         // Shifter sending data, preamble or break
  input  wire logic             tx_queue_other,  // Preamble or break queued
  output logic                  tx_valid,        // Byte offered to shifter
  input  wire logic             tx_ready,        // Shifter takes offered byte
  output logic      [WIDTH-1:0] tx_data,         // Offered byte
  output logic                  tx_ninth,        // Ninth bit loaded with byte
  output logic                  tx_buf_ready,    // Transmit buffer can accept a write
  output logic                  tx_irq,          // Transmitter interrupt request
  output logic                  rx_irq,          // Receiver interrupt request
  output logic                  err_irq          // Error interrupt request
);

  typedef logic [$clog2(DEPTH+1)-1:0] usdr_cnt_t;

  function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] b);
    return strobe && (a == b);
  endfunction

  // Status flags and control state
  logic [7:0]       stat1_ff,   nxt_stat1;
  logic [7:0]       arm1_ff,    nxt_arm1;
  logic             bkf_ff,     nxt_bkf;
  logic             bkarm_ff,   nxt_bkarm;
  logic             bkok_ff,    nxt_bkok;
  logic             rpf_ff,     nxt_rpf;
  logic             idleok_ff,  nxt_idleok;
  logic [3:0]       ones_ff,    nxt_ones;
  logic [3:0]       err_en_ff,  nxt_err_en;
  logic [7:0]       rdata_ff,   nxt_rdata;
  logic             txirq_ff,   nxt_txirq;
  logic             rxirq_ff,   nxt_rxirq;
  logic             erirq_ff,   nxt_erirq;
  // Transmit buffer
  usdr_cnt_t        cnt_ff,     nxt_cnt;
  logic             room_ff,    nxt_room;
  logic             valid_ff,   nxt_valid;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_mem [DEPTH];
  // Unreset data
  logic [7:0]       rxd_ff,     nxt_rxd;
  logic             rx8_ff,     nxt_rx8;
  logic             tx8_ff,     nxt_tx8;

  logic rd_s1, rd_s2, rd_d, wr_d, wr_c3;
  logic push, pop, accept, brk_set, idle_hit, full_now;
  logic [3:0] idle_len;
  usdr_cnt_t  cnt_after_pop;

  always_comb begin
    rd_s1  = hit(bus_rd, bus_addr, ADDR_STAT1);
    rd_s2  = hit(bus_rd, bus_addr, ADDR_STAT2);
    rd_d   = hit(bus_rd, bus_addr, ADDR_DATA);
    wr_d   = hit(bus_wr, bus_addr, ADDR_DATA);
    wr_c3  = hit(bus_wr, bus_addr, ADDR_CTRL3);
    pop    = valid_ff && tx_ready;
    push   = wr_d && room_ff;
    // Buffer freed by a clearing data read this cycle
    full_now = stat1_ff[S1_RXF] && !(rd_d && arm1_ff[S1_RXF]);
    accept = rx_char_done && !full_now;
    brk_set = rx_break && bkok_ff;
    idle_len = nine_bit_mode ? IDLE_LEN9 : IDLE_LEN8;

    nxt_stat1  = stat1_ff;
    nxt_arm1   = arm1_ff;
    nxt_bkf    = bkf_ff;
    nxt_bkarm  = bkarm_ff;
    nxt_bkok   = bkok_ff;
    nxt_rpf    = rpf_ff;
    nxt_idleok = idleok_ff;
    nxt_ones   = ones_ff;
    nxt_err_en = err_en_ff;
    nxt_rdata  = rdata_ff;
    nxt_rxd    = rxd_ff;
    nxt_rx8    = rx8_ff;
    nxt_tx8    = tx8_ff;

    // Clears by read sequence first, so hardware sets below win
    // Status one read snapshots set flags as clear arms
    if (rd_s1) begin
      nxt_arm1 = stat1_ff;
    end
    // Status two read arms only the break clear
    if (rd_s2) begin
      nxt_bkarm = bkf_ff;
    end
    if (rd_d) begin
      nxt_stat1[S1_RXF]  = stat1_ff[S1_RXF]  & ~arm1_ff[S1_RXF];
      nxt_stat1[S1_IDLE] = stat1_ff[S1_IDLE] & ~arm1_ff[S1_IDLE];
      nxt_stat1[S1_OR]   = stat1_ff[S1_OR]   & ~arm1_ff[S1_OR];
      nxt_stat1[S1_NF]   = stat1_ff[S1_NF]   & ~arm1_ff[S1_NF];
      nxt_stat1[S1_FE]   = stat1_ff[S1_FE]   & ~arm1_ff[S1_FE];
      nxt_stat1[S1_PE]   = stat1_ff[S1_PE]   & ~arm1_ff[S1_PE];
      nxt_bkf            = bkf_ff & ~bkarm_ff;
      if (arm1_ff[S1_IDLE] && stat1_ff[S1_IDLE]) begin
        nxt_idleok = 1'b0;
      end
      nxt_arm1[S1_RXF]  = 1'b0;
      nxt_arm1[S1_IDLE] = 1'b0;
      nxt_arm1[S1_OR]   = 1'b0;
      nxt_arm1[S1_NF]   = 1'b0;
      nxt_arm1[S1_FE]   = 1'b0;
      nxt_arm1[S1_PE]   = 1'b0;
      nxt_bkarm         = 1'b0;
    end
    if (wr_d) begin
      nxt_stat1[S1_TXE] = stat1_ff[S1_TXE] & ~arm1_ff[S1_TXE];
      nxt_arm1[S1_TXE]  = 1'b0;
    end

    // Receive character arrival
    if (rx_char_done) begin
      if (full_now) begin
        nxt_stat1[S1_OR] = 1'b1;
      end else begin
        nxt_rxd = rx_char[7:0];
        nxt_rx8 = nine_bit_mode ? rx_char[8] : rx_char[7];
        nxt_stat1[S1_RXF] = 1'b1;
        nxt_idleok = 1'b1;
      end
      if (accept && rx_noise) begin
        nxt_stat1[S1_NF] = 1'b1;
      end
      if (accept && rx_stop_zero) begin
        nxt_stat1[S1_FE] = 1'b1;
      end
      if (accept && rx_parity_bad) begin
        nxt_stat1[S1_PE] = 1'b1;
      end
    end

    // Break: flags set, break rearms only after ones
    if (brk_set) begin
      nxt_bkf = 1'b1;
      nxt_bkok = 1'b0;
      nxt_stat1[S1_FE] = 1'b1;
      nxt_stat1[S1_RXF] = 1'b1;
      if (!full_now) begin
        // Accepted break reads as a zero byte
        nxt_rxd = 8'h00;
        if (nine_bit_mode) begin
          nxt_rx8 = 1'b0;
        end
      end
    end else if (rx_bit_tick && rx_bit) begin
      nxt_bkok = 1'b1;
    end

    // Idle run counting
    idle_hit = 1'b0;
    if (rx_bit_tick) begin
      if (!rx_bit) begin
        nxt_ones = 4'h0;
      end else if (ones_ff < idle_len) begin
        nxt_ones = ones_ff + 4'h1;
        idle_hit = (ones_ff + 4'h1) == idle_len;
      end
    end
    if (idle_hit && idleok_ff) begin
      nxt_stat1[S1_IDLE] = 1'b1;
    end
    // Receiver off: idle waits for a fresh character
    if (!rx_enable) begin
      nxt_idleok = 1'b0;
      nxt_ones = 4'h0;
    end

    // Reception in progress, never an interrupt source
    if (rx_false_start || idle_hit) begin
      nxt_rpf = 1'b0;
    end else if (rx_start_zero) begin
      nxt_rpf = 1'b1;
    end

    // Transmit side flags
    if (pop) begin
      nxt_stat1[S1_TXE] = 1'b1;
    end
    // Complete only with buffer and shifter both empty
    nxt_stat1[S1_TC] = nxt_stat1[S1_TXE] && (nxt_cnt == '0) && !tx_busy
                       && !tx_queue_other && !push;
    if (!module_enable) begin
      nxt_stat1[S1_TXE] = 1'b1;
      nxt_stat1[S1_TC]  = 1'b1;
    end

    // Control register three writes
    if (wr_c3) begin
      nxt_tx8    = bus_wdata[C3_TX8];
      nxt_err_en = {bus_wdata[C3_OVERRUN_IRQ_EN], bus_wdata[C3_NOISE_IRQ_EN],
                    bus_wdata[C3_FRAMING_IRQ_EN], bus_wdata[C3_PARITY_IRQ_EN]};
    end

    // Read data, returned one cycle after the strobe
    if (bus_rd) begin
      case (bus_addr)
        ADDR_CTRL3: begin
          nxt_rdata = 8'h00;
          nxt_rdata[C3_RX8]  = rx8_ff;
          nxt_rdata[C3_TX8]  = tx8_ff;
          nxt_rdata[C3_OVERRUN_IRQ_EN] = err_en_ff[3];
          nxt_rdata[C3_NOISE_IRQ_EN] = err_en_ff[2];
          nxt_rdata[C3_FRAMING_IRQ_EN] = err_en_ff[1];
          nxt_rdata[C3_PARITY_IRQ_EN] = err_en_ff[0];
        end
        ADDR_STAT1: nxt_rdata = stat1_ff;
        ADDR_STAT2: begin
          nxt_rdata = 8'h00;
          nxt_rdata[S2_BKF] = bkf_ff;
          nxt_rdata[S2_RPF] = rpf_ff;
        end
        ADDR_DATA: nxt_rdata = rxd_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end

    // Interrupt requests
    nxt_txirq = module_enable && ((nxt_stat1[S1_TXE] && tx_empty_irq_en) ||
                                  (nxt_stat1[S1_TC] && tx_done_irq_en));
    nxt_rxirq = (nxt_stat1[S1_RXF] && rx_full_irq_en) ||
                (nxt_stat1[S1_IDLE] && idle_irq_en);
    nxt_erirq = |({nxt_stat1[S1_OR], nxt_stat1[S1_NF], nxt_stat1[S1_FE],
                   nxt_stat1[S1_PE]} & nxt_err_en);
  end

  // Head-out transmit buffer; entry zero drives the shifter
  always_comb begin
    cnt_after_pop = pop ? usdr_cnt_t'(cnt_ff - 1'b1) : cnt_ff;
    nxt_cnt = push ? usdr_cnt_t'(cnt_after_pop + 1'b1) : cnt_after_pop;
    // Registered so valid and ready leave straight from flops
    nxt_room  = (nxt_cnt != usdr_cnt_t'(DEPTH));
    nxt_valid = (nxt_cnt != '0);
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_txb
      always_comb begin
        nxt_mem[i] = mem_ff[i];
        // Entries move toward the head on each hand-off
        if (pop && (i < DEPTH - 1)) begin
          nxt_mem[i] = mem_ff[(i < DEPTH - 1) ? i + 1 : i];
        end
        if (push && (usdr_cnt_t'(i) == cnt_after_pop)) begin
          nxt_mem[i] = bus_wdata[WIDTH-1:0];
        end
      end
      always_ff @(posedge clock) begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat1_ff  <= STAT1_RST;
      arm1_ff   <= 8'h00;
      bkf_ff    <= 1'b0;
      bkarm_ff  <= 1'b0;
      bkok_ff   <= 1'b1;
      rpf_ff    <= 1'b0;
      idleok_ff <= 1'b0;
      ones_ff   <= 4'h0;
      err_en_ff <= ERR_EN_RST;
      rdata_ff  <= 8'h00;
      txirq_ff  <= 1'b0;
      rxirq_ff  <= 1'b0;
      erirq_ff  <= 1'b0;
      cnt_ff    <= '0;
      room_ff   <= 1'b1;
      valid_ff  <= 1'b0;
    end else begin
      stat1_ff  <= nxt_stat1;
      arm1_ff   <= nxt_arm1;
      bkf_ff    <= nxt_bkf;
      bkarm_ff  <= nxt_bkarm;
      bkok_ff   <= nxt_bkok;
      rpf_ff    <= nxt_rpf;
      idleok_ff <= nxt_idleok;
      ones_ff   <= nxt_ones;
      err_en_ff <= nxt_err_en;
      rdata_ff  <= nxt_rdata;
      txirq_ff  <= nxt_txirq;
      rxirq_ff  <= nxt_rxirq;
      erirq_ff  <= nxt_erirq;
      cnt_ff    <= nxt_cnt;
      room_ff   <= nxt_room;
      valid_ff  <= nxt_valid;
    end
  end

  // Data bits untouched by reset
  always_ff @(posedge clock) begin
    rxd_ff <= nxt_rxd;
    rx8_ff <= nxt_rx8;
    tx8_ff <= nxt_tx8;
  end

  always_comb begin
    bus_rdata    = rdata_ff;
    tx_valid     = valid_ff;
    tx_data      = mem_ff[0];
    tx_ninth     = tx8_ff;
    tx_buf_ready = room_ff;
    tx_irq       = txirq_ff;
    rx_irq       = rxirq_ff;
    err_irq      = erirq_ff;
  end

endmodule

`default_nettype wire

// >>> sim/usdr_chk.sv
// Assertion checker for the serial status and data register block
`timescale 1ns/10ps
`default_nettype none
module usdr_chk
  import usdr_pkg::*;
(
  input wire logic       clock,           // Clock
  input wire logic       arst_n,          // Reset
  input wire logic [7:0] bus_addr,        // Address
  input wire logic       bus_rd,          // Read
  input wire logic       bus_wr,          // Write
  input wire logic [7:0] bus_rdata,       // Read data
  input wire logic       module_enable,   // Enable
  input wire logic       tx_empty_irq_en, // Empty en
  input wire logic       tx_done_irq_en,  // Done en
  input wire logic       rx_full_irq_en,  // Full en
  input wire logic       rx_char_done,    // Char in
  input wire logic       rx_break,        // Break in
  input wire logic       rx_bit_tick,     // Bit tick
  input wire logic       rx_start_zero,   // Start
  input wire logic       rx_false_start,  // False start
  input wire logic       tx_busy,         // Busy
  input wire logic       tx_valid,        // Offered
  input wire logic       tx_ready,        // Taken
  input wire logic       tx_buf_ready,    // Space
  input wire logic       tx_irq,          // Tx irq
  input wire logic       rx_irq,          // Rx irq
  input wire logic       err_irq          // Err irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chk_unmapped_zero: assert property (bus_rd && bus_addr == 8'h00 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  chk_push_valid: assert property (bus_wr && bus_addr == ADDR_DATA && tx_buf_ready |=> tx_valid)
    else $error("written byte not offered");
  chk_pop_irq: assert property (tx_valid && tx_ready && module_enable && tx_empty_irq_en
    |-> ##[1:2] tx_irq) else $error("no transmit irq after hand-off");
  chk_disable_mask: assert property (!module_enable [*2] |-> !tx_irq)
    else $error("transmit irq while disabled");
  chk_busy_no_done: assert property ((module_enable && tx_done_irq_en && !tx_empty_irq_en
    && tx_busy) [*3] |-> !tx_irq) else $error("complete irq while sending");
  chk_full_irq: assert property (rx_char_done && rx_full_irq_en ##1 rx_full_irq_en |-> rx_irq)
    else $error("no receive irq");
  chk_err_cause: assert property ($rose(err_irq) |-> $past(rx_char_done || rx_break || bus_wr))
    else $error("error irq without cause");
  chk_rpf_set: assert property (rx_start_zero && !rx_false_start && !rx_bit_tick
    ##1 !rx_false_start && !rx_bit_tick ##1 bus_rd && bus_addr == ADDR_STAT2
    |=> bus_rdata[S2_RPF]) else $error("progress flag not set");
  cover property (rx_char_done && rx_irq);
  cover property (tx_valid && !tx_buf_ready);
  cover property (rx_break);
endmodule
bind usdr_regs usdr_chk chk (.*);
`default_nettype wire

// >>> sim/usdr_peer.sv
// Transmit shifter model on the far side of the data buffer
`timescale 1ns/10ps
`default_nettype none
module usdr_peer (
  input  wire logic       clock,    // Clock
  input  wire logic       arst_n,   // Reset
  input  wire logic       tx_valid, // Offered
  input  wire logic [7:0] tx_data,  // Byte
  input  wire logic       tx_ninth, // Ninth bit
  input  wire logic       stall,    // Hold off loads
  output logic            tx_ready, // Load now
  output logic            tx_busy,  // Shifting
  output logic            got,      // Loaded last cycle
  output logic      [8:0] got_word  // Loaded word
);
  logic [2:0] bcnt_ff;
  assign tx_ready = bcnt_ff == 3'h0 && !stall;
  assign tx_busy = bcnt_ff != 3'h0;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_ff <= 3'h0;
      got <= 1'b0;
      got_word <= 9'h000;
    end else begin
      got <= tx_valid && tx_ready;
      if (tx_valid && tx_ready) begin
        got_word <= {tx_ninth, tx_data};
        bcnt_ff <= 3'h4;
      end else if (bcnt_ff != 3'h0) begin
        bcnt_ff <= bcnt_ff - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the serial status and data register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top
  import usdr_pkg::*;
;
  logic clock = 0, arst_n = 0, bus_rd = 0, bus_wr = 0, stall = 1, module_enable = 1;
  logic [7:0] bus_addr = 0, bus_wdata = 0, bus_rdata, d, tx_data;
  logic rx_enable = 1, nine_bit_mode = 0, tx_empty_irq_en = 1, tx_done_irq_en = 0;
  logic rx_full_irq_en = 1, idle_irq_en = 1, rx_char_done = 0, rx_noise = 0;
  logic rx_stop_zero = 0, rx_parity_bad = 0, rx_break = 0, rx_bit_tick = 0, rx_bit = 1;
  logic rx_start_zero = 0, rx_false_start = 0, tx_queue_other = 0, tx_busy, tx_valid;
  logic tx_ready, tx_ninth, tx_buf_ready, tx_irq, rx_irq, err_irq, got;
  logic [8:0] rx_char = 0, got_word, w;
  logic [5:0] mf = 0, ma = 0; // full idle overrun noise framing parity
  logic [7:0] md;
  logic [3:0] en;
  logic [1:0] xt = 2'b11;
  logic mr8, xi, break_detect_flag = 0, bka = 0, rx_in_progress = 0, ok = 0;
  logic [31:0] seed = 32'ha2f6, r;
  logic [8:0] txq[$];
  int cnt = 0, n_mismatch = 0, n_checks = 0, cycles = 0;
  usdr_regs uut (.*);
  usdr_peer peer (.*);
  initial forever #20 clock = ~clock;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, input logic wr, input logic [7:0] v);
    @(negedge clock);
    if (wr && a == ADDR_DATA && tx_buf_ready) txq.push_back({1'b1, v});
    {bus_addr, bus_wdata, bus_rd, bus_wr} = {a, v, !wr, wr};
    @(negedge clock);
    {bus_rd, bus_wr} = 2'b00;
    d = bus_rdata;
  endtask
  task automatic rs1();
    acc(ADDR_STAT1, 0, 0);
    `CHK("status1", {xt, mf}, d)
    `CHK("rx_irq", mf[5] & rx_full_irq_en | mf[4] & idle_irq_en, rx_irq)
    `CHK("err_irq", |(mf[3:0] & en), err_irq)
    xi = module_enable & (xt[1] & tx_empty_irq_en | xt[0] & tx_done_irq_en);
    `CHK("tx_irq", xi, tx_irq)
    ma = mf;
  endtask
  task automatic rs2();
    acc(ADDR_STAT2, 0, 0);
    `CHK("status2", {6'h00, break_detect_flag, rx_in_progress}, d)
    bka = break_detect_flag;
  endtask
  task automatic rdd();
    acc(ADDR_DATA, 0, 0);
    `CHK("data", md, d)
    if (ma[4]) ok = 0;
    mf &= ~ma;
    ma = 0;
    if (bka) break_detect_flag = 0;
    bka = 0;
  endtask
  task automatic c3();
    acc(ADDR_CTRL3, 0, 0);
    `CHK("ctrl3", {mr8, 1'b1, 2'b00, en}, d)
  endtask
  task automatic rxc(input logic [8:0] c, input logic [2:0] q);
    @(negedge clock);
    {rx_char_done, rx_char, rx_noise, rx_stop_zero, rx_parity_bad} = {1'b1, c, q};
    @(negedge clock);
    rx_char_done = 0;
    if (mf[5]) mf[3] = 1;
    else begin
      md = c[7:0];
      mr8 = nine_bit_mode ? c[8] : c[7];
      mf = mf | {1'b1, 2'b00, q};
      ok = 1;
    end
  endtask
  task automatic tick(input int n, input logic b);
    repeat (n) begin
      @(negedge clock);
      {rx_bit_tick, rx_bit} = {1'b1, b};
      @(negedge clock);
      rx_bit_tick = 0;
      cnt = b ? cnt + 1 : 0;
      if (cnt == (nine_bit_mode ? 11 : 10)) begin
        rx_in_progress = 0;
        if (ok) mf[4] = 1;
      end
    end
  endtask
  task automatic pls(input int k);
    @(negedge clock);
    {rx_break, rx_false_start, rx_start_zero} = 3'b001 << k;
    @(negedge clock);
    {rx_break, rx_false_start, rx_start_zero} = 3'b000;
  endtask
  task automatic drain();
    int k = 0;
    while ((txq.size() != 0 || tx_busy || tx_valid) && k < 200) begin
      @(negedge clock);
      k++;
    end
    if (k >= 200) n_mismatch++;
    repeat (2) @(negedge clock);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (got) begin
      w = txq.pop_front();
      `CHK("tx word", w, got_word)
    end
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(negedge clock);
    arst_n = 1;
    acc(ADDR_CTRL3, 0, 0);
    `CHK("ctrl3 reset", 6'h00, d[5:0])
    rs1();
    rs2();
    acc(8'h00, 0, 0);
    `CHK("unmapped", 8'h00, d)
    r = xs();
    en = r[3:0];
    acc(ADDR_CTRL3, 1, {4'h4, en});
    repeat (40) begin
      r = xs();
      if (!mf[5]) nine_bit_mode = r[20];
      rxc(r[8:0], r[11:9] & {3{r[12]}});
      if (r[13]) rs1();
      if (r[13] & r[14]) begin
        rdd();
        c3();
      end
    end
    rs1();
    rdd();
    rxc(r[24:16], 3'h0);
    rs1();
    rxc(9'h0a5, 3'h0);
    rdd();
    rs1();
    for (int m = 0; m < 2; m++) begin
      nine_bit_mode = m[0];
      @(negedge clock);
      rx_enable = 0;
      @(negedge clock);
      {rx_enable, cnt, ok} = {1'b1, 32'h0, 1'b0};
      tick(12, 1);
      rs1();
      r = xs();
      rxc(r[8:0], 3'h0);
      rs1();
      rdd();
      pls(0);
      rx_in_progress = 1;
      rs2();
      tick(1, 0);
      tick(9 + m, 1);
      rs1();
      tick(1, 1);
      rs1();
      rs2();
      rdd();
      tick(1, 0);
      tick(12, 1);
      rs1();
    end
    pls(0);
    pls(1);
    rs2();
    rs1();
    for (int i = 0; i < 3; i++) acc(ADDR_DATA, 1, 8'(xs() >> 8));
    xt = 2'b00;
    `CHK("buf ready", 1'b0, tx_buf_ready)
    rs1();
    stall = 0;
    drain();
    xt = 2'b11;
    rs1();
    {tx_empty_irq_en, tx_done_irq_en} = 2'b01;
    acc(ADDR_DATA, 1, 8'h3c);
    drain();
    stall = 1;
    acc(ADDR_DATA, 1, 8'hc3);
    xt = 2'b10;
    rs1();
    module_enable = 0;
    xt = 2'b11;
    rs1();
    module_enable = 1;
    stall = 0;
    drain();
    {tx_queue_other, xt} = 3'b110;
    rs1();
    tx_queue_other = 0;
    nine_bit_mode = 1;
    tick(1, 1);
    pls(2);
    if (!mf[5]) {md, mr8} = 9'h000;
    {break_detect_flag, mf[5], mf[1], xt} = 5'b11111;
    rs1();
    rs2();
    rdd();
    c3();
    pls(2);
    rs2();
    end_of_test();
  end
endmodule
`default_nettype wire
